/* inc/flash_access_pkg.sv */
// Constants and carrier types for the flash wait-state access block
package flash_access_pkg;

  // Clock and widths
  localparam int          CLK_MHZ      = 250;
  localparam int          ADDR_W       = 24;
  localparam int          DATA_W       = 16;
  localparam int          WAIT_CODE_W  = 2;
  localparam int          WAIT_CNT_W   = 2;
  localparam int          OP_CNT_W     = 27;

  // Wait-count field encodings
  localparam logic [1:0]  WAIT_CODE_0  = 2'h0;
  localparam logic [1:0]  WAIT_CODE_1  = 2'h1;
  localparam logic [1:0]  WAIT_CODE_2  = 2'h2;
  localparam logic [1:0]  WAIT_CODE_R  = 2'h3;
  localparam logic [1:0]  WAIT_CYC_0   = 2'h0;
  localparam logic [1:0]  WAIT_CYC_1   = 2'h1;
  localparam logic [1:0]  WAIT_CYC_2   = 2'h2;

  // Program and erase durations
  localparam int          PROG_BLOCK_BYTES = 128;
  localparam int          PROG_MAX_MS      = 5;
  localparam int          PROG_TYP_MS      = 2;
  localparam int          ERASE_MAX_MS     = 500;
  localparam int          ERASE_TYP_MS     = 200;
  localparam int          PROG_MAX_CYC     = PROG_MAX_MS * 1000 * CLK_MHZ;
  localparam int          ERASE_MAX_CYC    = ERASE_MAX_MS * 1000 * CLK_MHZ;

  // Reset values
  localparam logic [DATA_W-1:0] RDATA_RST  = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST   = 24'h000000;

  typedef enum logic [1:0]
  {
    ACC_IDLE   = 2'h1,
    ACC_ACTIVE = 2'h2
  } access_state_type;

  typedef struct packed
  {
    logic              valid;
    logic              seq;
    logic [ADDR_W-1:0] addr;
  } access_req_type;

  typedef struct packed
  {
    logic              valid;
    logic [DATA_W-1:0] data;
  } read_resp_type;

endpackage

/* verilog/flash_op_timer.sv */
// Duration supervisor for one flash program or erase operation
`timescale 1ns/10ps
module flash_op_timer
  import flash_access_pkg::*;
#(
  parameter int               CNT_W = OP_CNT_W,
  parameter logic [CNT_W-1:0] LIMIT = CNT_W'(PROG_MAX_CYC)
)
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Control
  input  wire logic i_start,
  input  wire logic i_done,
  // Status
  output logic      o_busy,
  output logic      o_timeout
);

  logic             busy_reg;
  logic             busy_next;
  logic             timeout_reg;
  logic             timeout_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  // Refuse a zero limit at elaboration
  if (LIMIT == '0)
    $error("flash_op_timer: LIMIT must be at least one cycle");

  always_comb
  begin
    busy_next    = busy_reg;
    timeout_next = timeout_reg;
    cnt_next     = cnt_reg;
    if (busy_reg)
    begin
      if (i_done)
        busy_next = 1'b0;
      else if (cnt_reg == LIMIT - CNT_W'(1))
      begin
        // Array overran its worst-case time; abandon the operation
        busy_next    = 1'b0;
        timeout_next = 1'b1;
      end
      else
        cnt_next = cnt_reg + CNT_W'(1);
    end
    else if (i_start)
    begin
      // Start clears the previous timeout flag
      busy_next    = 1'b1;
      timeout_next = 1'b0;
      cnt_next     = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      busy_reg    <= 1'b0;
      timeout_reg <= 1'b0;
      cnt_reg     <= '0;
    end
    else
    begin
      busy_reg    <= busy_next;
      timeout_reg <= timeout_next;
      cnt_reg     <= cnt_next;
    end
  end

  assign o_busy    = busy_reg;
  assign o_timeout = timeout_reg;

endmodule

/* verilog/flash_wait_state_access.sv */
// Flash array access sequencer with programmable wait states
`timescale 1ns/10ps
module flash_wait_state_access
  import flash_access_pkg::*;
#(
  parameter int               CNT_W       = OP_CNT_W,
  parameter logic [CNT_W-1:0] PROG_LIMIT  = CNT_W'(PROG_MAX_CYC),
  parameter logic [CNT_W-1:0] ERASE_LIMIT = CNT_W'(ERASE_MAX_CYC)
)
(
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_resetn,
  // Wait-count setting from the memory bus control
  input  wire logic [WAIT_CODE_W-1:0] i_flash_wait_count,
  // Request and answer towards the program memory interface unit
  input  wire access_req_type         i_req,
  output logic                        o_ready,
  output read_resp_type               o_resp,
  // Flash array read port
  output logic                        o_flash_rd,
  output logic [ADDR_W-1:0]           o_flash_addr,
  input  wire logic [DATA_W-1:0]      i_flash_data,
  // Program and erase supervision
  input  wire logic                   i_prog_start,
  input  wire logic                   i_erase_start,
  input  wire logic                   i_op_done,
  output logic                        o_prog_busy,
  output logic                        o_prog_timeout,
  output logic                        o_erase_busy,
  output logic                        o_erase_timeout
);

  // Refuse unusable settings at elaboration
  if (CNT_W < 2 || CNT_W > 31)
    $error("flash_wait_state_access: CNT_W out of range");
  if (PROG_LIMIT == '0 || ERASE_LIMIT == '0)
    $error("flash_wait_state_access: limits must be nonzero");

  // Reset release through two flops
  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end
    else
    begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  assign rst_n = rst_sync2_reg;

  // Decode wait-count field into wait cycles
  function automatic logic [WAIT_CNT_W-1:0] wait_cycles
  (
    input logic [WAIT_CODE_W-1:0] code
  );
    case (code)
      WAIT_CODE_0: wait_cycles = WAIT_CYC_0;
      WAIT_CODE_1: wait_cycles = WAIT_CYC_1;
      WAIT_CODE_2: wait_cycles = WAIT_CYC_2;
      // Reserved code falls back to the slowest setting for safety
      default:     wait_cycles = WAIT_CYC_2;
    endcase
  endfunction

  access_state_type        state_reg;
  access_state_type        state_next;
  logic [WAIT_CNT_W-1:0]   wait_reg;
  logic [WAIT_CNT_W-1:0]   wait_next;
  logic [ADDR_W-1:0]       addr_reg;
  logic [ADDR_W-1:0]       addr_next;
  logic                    rd_reg;
  logic                    rd_next;
  logic                    ready_reg;
  logic                    ready_next;
  read_resp_type           resp_reg;
  read_resp_type           resp_next;
  logic                    prog_busy;
  logic                    erase_busy;
  logic                    op_busy;
  logic                    take;
  logic                    op_start;

  // Reads are refused while the array is being programmed or erased
  assign op_busy = prog_busy | erase_busy;
  assign take    = ready_reg & i_req.valid;
  // A read taken in the same cycle keeps the array; the start is dropped
  assign op_start = (i_prog_start | i_erase_start) & ~op_busy & ~rd_reg
                    & ~take;

  always_comb
  begin
    state_next     = state_reg;
    wait_next      = wait_reg;
    addr_next      = addr_reg;
    rd_next        = rd_reg;
    resp_next      = resp_reg;
    resp_next.valid = 1'b0;
    case (state_reg)
      ACC_IDLE:
      begin
        if (take)
        begin
          state_next = ACC_ACTIVE;
          addr_next  = i_req.addr;
          rd_next    = 1'b1;
          // Prefetched sequential fetches skip the wait states
          if (i_req.seq)
            wait_next = WAIT_CYC_0;
          else
            wait_next = wait_cycles(i_flash_wait_count);
        end
      end
      ACC_ACTIVE:
      begin
        if (wait_reg == WAIT_CYC_0)
        begin
          // Final access cycle: capture and answer next cycle
          state_next      = ACC_IDLE;
          rd_next         = 1'b0;
          resp_next.valid = 1'b1;
          resp_next.data  = i_flash_data;
        end
        else
          wait_next = wait_reg - WAIT_CNT_W'(1);
      end
      default:
      begin
        state_next = ACC_IDLE;
        rd_next    = 1'b0;
      end
    endcase
    // Held off until the cycle in which the answer goes out
    // Starting op closes the port at once, not one cycle late
    ready_next = (state_next == ACC_IDLE) && !op_busy && !op_start;
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg  <= ACC_IDLE;
      wait_reg   <= WAIT_CYC_0;
      addr_reg   <= ADDR_RST;
      rd_reg     <= 1'b0;
      ready_reg  <= 1'b0;
      resp_reg   <= '{valid: 1'b0, data: RDATA_RST};
    end
    else
    begin
      state_reg  <= state_next;
      wait_reg   <= wait_next;
      addr_reg   <= addr_next;
      rd_reg     <= rd_next;
      ready_reg  <= ready_next;
      resp_reg   <= resp_next;
    end
  end

  assign o_ready      = ready_reg;
  assign o_resp       = resp_reg;
  assign o_flash_rd   = rd_reg;
  assign o_flash_addr = addr_reg;

  // One program block at a time; start ignored while either runs
  flash_op_timer
  #(
    .CNT_W (CNT_W),
    .LIMIT (PROG_LIMIT)
  )
  u_prog_timer
  (
    .i_clk     (i_clk),
    .i_rst_n   (rst_n),
    .i_start   (op_start & i_prog_start),
    .i_done    (i_op_done),
    .o_busy    (prog_busy),
    .o_timeout (o_prog_timeout)
  );

  flash_op_timer
  #(
    .CNT_W (CNT_W),
    .LIMIT (ERASE_LIMIT)
  )
  u_erase_timer
  (
    .i_clk     (i_clk),
    .i_rst_n   (rst_n),
    .i_start   (op_start & i_erase_start & ~i_prog_start),
    .i_done    (i_op_done),
    .o_busy    (erase_busy),
    .o_timeout (o_erase_timeout)
  );

  assign o_prog_busy  = prog_busy;
  assign o_erase_busy = erase_busy;

endmodule

/* test/flash_array_model.sv */
// Behavioural flash array answering reads with an address-derived word
`timescale 1ns/10ps
module flash_array_model
  import flash_access_pkg::*;
(
  input  wire logic              i_rd,
  input  wire logic [ADDR_W-1:0] i_addr,
  output logic [DATA_W-1:0]      o_data
);
  // Unselected array shows the inverse, so stale data cannot pass
  assign o_data = {DATA_W{!i_rd}} ^ i_addr[15:0] ^ 16'hA5C3;
endmodule

/* test/flash_wait_state_access_props.sv */
// Checker properties for the flash wait-state access block
`timescale 1ns/10ps
module flash_wait_state_access_props
  import flash_access_pkg::*;
#(
  parameter int               CNT_W       = OP_CNT_W,
  parameter logic [CNT_W-1:0] PROG_LIMIT  = CNT_W'(PROG_MAX_CYC),
  parameter logic [CNT_W-1:0] ERASE_LIMIT = CNT_W'(ERASE_MAX_CYC)
)
(
  // Clock and reset
  input wire logic                   i_clk,
  input wire logic                   i_resetn,
  // Access side
  input wire logic [WAIT_CODE_W-1:0] i_flash_wait_count,
  input wire access_req_type         i_req,
  input wire logic                   o_ready,
  input wire read_resp_type          o_resp,
  input wire logic                   o_flash_rd,
  input wire logic [ADDR_W-1:0]      o_flash_addr,
  input wire logic [DATA_W-1:0]      i_flash_data,
  // Supervision
  input wire logic                   o_prog_busy,
  input wire logic                   o_prog_timeout,
  input wire logic                   o_erase_busy
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic             nseq;
  logic [CNT_W-1:0] prog_reg;
  logic [CNT_W-1:0] erase_reg;
  assign nseq = o_ready && i_req.valid && !i_req.seq;
  // Busy-cycle counters stand in for long repetitions
  always_ff @(posedge i_clk or negedge i_resetn)
    if (!i_resetn)
    begin
      prog_reg  <= '0;
      erase_reg <= '0;
    end
    else
    begin
      prog_reg  <= o_prog_busy ? prog_reg + 1'b1 : '0;
      erase_reg <= o_erase_busy ? erase_reg + 1'b1 : '0;
    end
  a_seq_fetch: assert property (o_ready && i_req.valid && i_req.seq
    |=> o_flash_rd ##1 !o_flash_rd && o_resp.valid) else $error("seq len");
  a_zero_wait: assert property (nseq && i_flash_wait_count == 2'h0
    |=> o_flash_rd ##1 !o_flash_rd && o_resp.valid) else $error("0 ws");
  a_one_wait: assert property (nseq && i_flash_wait_count == 2'h1
    |=> o_flash_rd[*2] ##1 !o_flash_rd && o_resp.valid) else $error("1 ws");
  a_two_wait: assert property (nseq && i_flash_wait_count[1]
    |=> o_flash_rd[*3] ##1 !o_flash_rd && o_resp.valid) else $error("2 ws");
  a_addr_capture: assert property (o_ready && i_req.valid
    |=> o_flash_addr == $past(i_req.addr)) else $error("address");
  a_data_return: assert property (o_resp.valid
    |-> o_resp.data == $past(i_flash_data)) else $error("data");
  a_busy_refuse: assert property (o_prog_busy || o_erase_busy
    |=> !o_ready) else $error("read during op");
  a_op_block: assert property (o_prog_busy || o_erase_busy
    |-> !o_ready) else $error("ready during op");
  a_prog_bound: assert property (prog_reg <= PROG_LIMIT)
    else $error("program too long");
  a_erase_bound: assert property (erase_reg <= ERASE_LIMIT)
    else $error("erase too long");
  c_seq: cover property (o_ready && i_req.valid && i_req.seq);
  c_two: cover property (nseq && i_flash_wait_count == 2'h2);
  c_tout: cover property ($rose(o_prog_timeout));
endmodule

bind flash_wait_state_access flash_wait_state_access_props #(.CNT_W(CNT_W),
  .PROG_LIMIT(PROG_LIMIT), .ERASE_LIMIT(ERASE_LIMIT)) i_props (.i_clk,
  .i_resetn, .i_flash_wait_count, .i_req, .o_ready, .o_resp, .o_flash_rd,
  .o_flash_addr, .i_flash_data, .o_prog_busy, .o_prog_timeout, .o_erase_busy);

/* test/flash_wait_state_access_test.sv */
// Self-checking bench for the flash wait-state access block
`timescale 1ns/10ps
module flash_wait_state_access_test
  import flash_access_pkg::*;
;
  logic              i_clk, i_resetn, o_ready, o_flash_rd;
  logic [1:0]        i_flash_wait_count;
  access_req_type    i_req;
  read_resp_type     o_resp;
  logic [ADDR_W-1:0] o_flash_addr;
  logic [DATA_W-1:0] i_flash_data;
  logic              i_prog_start, i_erase_start, i_op_done;
  logic              o_prog_busy, o_prog_timeout;
  logic              o_erase_busy, o_erase_timeout;
  int                miscompares = 0, checked = 0, cyc = 0, w;
  int                due_q[$];
  logic [15:0]       dat_q[$];

  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // Short limits keep the timeouts reachable
  flash_wait_state_access #(.PROG_LIMIT(27'h14), .ERASE_LIMIT(27'h32))
    i_flash_wait_state_access (.i_clk, .i_resetn, .i_flash_wait_count,
    .i_req, .o_ready, .o_resp, .o_flash_rd, .o_flash_addr, .i_flash_data,
    .i_prog_start, .i_erase_start, .i_op_done, .o_prog_busy,
    .o_prog_timeout, .o_erase_busy, .o_erase_timeout);
  flash_array_model i_flash_array_model (.i_rd(o_flash_rd),
    .i_addr(o_flash_addr), .o_data(i_flash_data));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Reference model: answer due 2 + waits cycles after the take
  always @(posedge i_clk)
  begin
    cyc++;
    if (i_resetn && o_resp.valid)
    begin
      // An answer with nothing outstanding is a mismatch by itself
      if (due_q.size() == 0)
        check(1'b1, 1'b0);
      else
      begin
        check(cyc, due_q.pop_front());
        check(o_resp.data, dat_q.pop_front());
      end
    end
    if (i_resetn && o_ready && i_req.valid)
    begin
      check(o_prog_busy | o_erase_busy, 1'b0);
      w = i_req.seq ? 0 : (i_flash_wait_count[1] ? 2 : i_flash_wait_count);
      due_q.push_back(cyc + 2 + w);
      dat_q.push_back(i_req.addr[15:0] ^ 16'hA5C3);
    end
    if (cyc > 1500)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  // Next request waits on the bus, refused until ready
  task automatic reads(input int n);
    repeat (n)
    begin
      #1 i_req = '{1'b1, 1'($urandom), ADDR_W'($urandom)};
      i_flash_wait_count = 2'($urandom);
      do @(posedge i_clk); while (o_ready !== 1'b1);
    end
    #1 i_req.valid = 1'b0;
    @(posedge i_clk);
  endtask

  task automatic op(input logic prog, input int d);
    repeat (4) @(posedge i_clk);
    #1 {i_prog_start, i_erase_start} = {prog, !prog};
    @(posedge i_clk);
    #1 {i_prog_start, i_erase_start} = 2'h0;
    i_req = '{1'b1, 1'b0, ADDR_W'($urandom)};
    repeat (d ? d : 60) @(posedge i_clk);
    #1 check(prog ? o_prog_busy : o_erase_busy, d != 0);
    i_op_done = d != 0;
    @(posedge i_clk);
    #1 i_op_done = 1'b0;
    check(prog ? {o_prog_busy, o_prog_timeout}
      : {o_erase_busy, o_erase_timeout}, {1'b0, d == 0});
    do @(posedge i_clk); while (o_ready !== 1'b1);
    #1 i_req.valid = 1'b0;
    @(posedge i_clk);
  endtask

  initial
  begin
    {i_resetn, i_prog_start, i_erase_start, i_op_done} = 4'h0;
    i_req = '0;
    i_flash_wait_count = 2'h0;
    void'($urandom(32'hBBDA));
    repeat (5) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    @(posedge i_clk);
    reads(30);
    op(1'b1, 0);
    op(1'b1, 5);
    op(1'b0, 0);
    op(1'b0, 5);
    reads(20);
    repeat (6) @(posedge i_clk);
    check(due_q.size(), 0);
    report_and_stop();
  end
endmodule
